// ===== rtl/fpfmt_regs.svh
// constants of the operand format converter: biases, field positions, counts
// assumes it is included by bare name from the converter core
`ifndef FPFMT_REGS_SVH
`define FPFMT_REGS_SVH

// ------------------------------------------------------------
// exponent biases and limits, signed 18-bit working width except the 15-bit extended exponent maximum
// ------------------------------------------------------------
`define SGL_BIAS   18'sh0007f
`define DBL_BIAS   18'sh003ff
`define EXT_BIAS   18'sh03fff
`define SGL_EMAX   18'sh000ff
`define DBL_EMAX   18'sh007ff
`define EXT_EXP_MAX 15'h7fff

// ------------------------------------------------------------
// field positions inside the 80-bit operand image
// ------------------------------------------------------------
`define SGL_SIGN   31
`define DBL_SIGN   63
`define PBCD_SIGN  79
`define BCD_DIGITS 18
`define INT_TOP    18'sh0003f

// ------------------------------------------------------------
// fixed values, reset values and counts
// ------------------------------------------------------------
`define QNAN_SIG   64'hc000_0000_0000_0000
`define BCD_LIMIT  64'h0de0_b6b3_a764_0000
`define INT16_INDEF 16'h8000
`define INT32_INDEF 32'h8000_0000
`define INT64_INDEF 64'h8000_0000_0000_0000
`define RESET_TOP  3'h0
`define SQRT_STEPS 7'h40
`define NUM_REGS   8

`endif

// ===== rtl/fpfmt_pkg.sv
// types shared by the operand format converter and its testbench
// assumes fpfmt_regs.svh is on the include path
package fpfmt_pkg;

	// ------------------------------------------------------------
	// commands and formats
	// ------------------------------------------------------------
	typedef enum logic [2:0] {OP_LOAD, OP_STORE, OP_STORE_POP, OP_SQRT, OP_COMPARE} op_t;
	typedef enum logic [2:0] {FMT_INT16, FMT_INT32, FMT_INT64, FMT_SGL, FMT_DBL, FMT_EXT, FMT_BCD} fmt_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        sign;
		logic [14:0] exp;
		logic [63:0] sig;
	} ext_t;

	typedef struct packed {
		op_t         op;
		fmt_t        fmt;
		logic        use_reg;
		logic [2:0]  idx;
		logic [79:0] operand;
	} cmd_t;

	typedef struct packed {
		logic [79:0] data;
		logic        range_err;
		logic        less;
		logic        equal;
		logic        unordered;
	} res_t;

endpackage

// ===== rtl/stack_regfile.sv
// eight-entry data register store of the converter, one write and one read port
// assumes read address is presented one cycle before its data is used
`timescale 1ns/100ps
`default_nettype none

module stack_regfile #(
	parameter int unsigned WIDTH = 80,
	parameter int unsigned DEPTH = 8,
	parameter int unsigned AW    = 3
) (
	input  wire logic             clk,     // core clock
	input  wire logic             wr_en,   // write strobe
	input  wire logic [AW-1:0]    wr_addr, // write slot
	input  wire logic [WIDTH-1:0] wr_data, // write word
	input  wire logic [AW-1:0]    rd_addr, // read slot
	output logic      [WIDTH-1:0] rd_data  // registered read word
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH != (1 << AW)) begin : g_bad_depth
		$error("stack_regfile: DEPTH must equal 2**AW");
	end

	// contents carry no reset; software sees a slot only after writing it
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

`default_nettype wire

// ===== rtl/numeric_format_converter.sv
// operand format path of the numeric coprocessor: loads, stores, compare, root
// assumes the host hands over whole operands, byte 0 in bits 7:0
`timescale 1ns/100ps
`default_nettype none
`include "fpfmt_regs.svh"

// Function
// - every load turns a 16/32/64-bit integer, 32/64-bit real or 18-digit decimal into extended form
// - every store turns the extended value back into the format the command names
// - all values held inside are kept in extended form only
// - operands are little-endian, lowest byte or digit at the lowest address
// - packed decimal holds 18 digits two per byte with the sign in bit 79
// - decimal filler bits are ignored on load and written as zero on store
// - a sign bit of zero means positive and one means negative in every signed format
// - normalized single and double reals use biases 127 and 1023
// - normalized extended reals use bias 16383
// - the integer bit is explicit in extended form and implied in single and double
// - the command slot accepts the next command while the current one executes
// - the host does all memory access and the block works only on what it is handed
// - a two-operand command takes one operand from a data register and the other from one register or memory
// - the square root command takes its operand from the top of the stack
// - each of the eight data registers is 80 bits wide in extended layout
module numeric_format_converter
	import fpfmt_pkg::*;
#(
	parameter int unsigned NREGS = `NUM_REGS
) (
	input  wire logic CORE_CLK,  // core clock, 250 MHz
	input  wire logic RST,       // synchronous reset, active high
	input  wire logic CMD_VALID, // host offers a command
	output logic      CMD_READY, // command slot is free
	input  wire cmd_t CMD_IN,    // command with its memory operand
	output logic      RES_VALID, // one-cycle result strobe
	output res_t      RES_OUT,   // store image or compare flags
	output logic      BUSY,      // command pending or executing
	output logic [2:0] TOP_OUT   // current top-of-stack slot
);
	if (NREGS != 8) begin : g_bad_regs
		$error("numeric_format_converter: NREGS must be 8");
	end

	typedef enum {S_IDLE, S_WAIT_A, S_WAIT_B, S_EXEC, S_SQRT} state_t;

	// ------------------------------------------------------------
	// conversion functions
	// ------------------------------------------------------------
	// any source to extended form; extended images pass through unchanged, other finite sources come out normalized or zero
	function automatic ext_t to_ext(fmt_t fmt, logic [79:0] op);
		logic               s;
		logic signed [17:0] x;
		logic [63:0]        m;
		logic signed [63:0] iv;
		logic [6:0]         lz;
		ext_t               r;
		s  = 1'b0;
		x  = `INT_TOP;
		m  = 64'h0;
		iv = 64'h0;
		lz = 7'h0;
		r  = '0;
		case (fmt)
			FMT_INT16, FMT_INT32, FMT_INT64: begin
				if (fmt == FMT_INT16) iv = {{48{op[15]}}, op[15:0]};
				else if (fmt == FMT_INT32) iv = {{32{op[31]}}, op[31:0]};
				else iv = op[63:0];
				s = iv[63];
				m = s ? 64'(-iv) : 64'(iv);
			end
			FMT_SGL: begin
				s = op[`SGL_SIGN];
				m = {(op[30:23] != 8'h00), op[22:0], 40'h0};
				x = $signed({10'h0, (op[30:23] == 8'h00) ? 8'h01 : op[30:23]}) - `SGL_BIAS;
			end
			FMT_DBL: begin
				s = op[`DBL_SIGN];
				m = {(op[62:52] != 11'h000), op[51:0], 11'h0};
				x = $signed({7'h0, (op[62:52] == 11'h000) ? 11'h001 : op[62:52]}) - `DBL_BIAS;
			end
			FMT_BCD: begin
				s = op[`PBCD_SIGN];
				// bits 78:72 are filler and never looked at
				for (int i = `BCD_DIGITS - 1; i >= 0; i--) begin
					m = 64'(m * 64'd10) + {60'h0, op[4*i +: 4]};
				end
			end
			default: begin
				s = op[79];
				m = op[63:0];
				x = $signed({3'h0, op[78:64]}) - `EXT_BIAS;
			end
		endcase
		for (int i = 0; i < 64; i++) begin
			if (m[i]) lz = 7'(63 - i);
		end
		// infinities and nans keep their pattern, the integer bit made explicit
		if (fmt == FMT_SGL && op[30:23] == 8'hff) begin
			r = {s, `EXT_EXP_MAX, 1'b1, op[22:0], 40'h0};
		end else if (fmt == FMT_DBL && op[62:52] == 11'h7ff) begin
			r = {s, `EXT_EXP_MAX, 1'b1, op[51:0], 11'h0};
		end else if (fmt == FMT_EXT) begin
			r = op;
		end else if (m == 64'h0) begin
			r = {s, 79'h0};
		end else begin
			r.sign = s;
			r.sig  = m << lz;
			r.exp  = 15'(x - $signed({11'h0, lz}) + `EXT_BIAS);
		end
		return r;
	endfunction

	// integer magnitude after truncation toward zero, with overflow bit on top
	function automatic logic [64:0] trunc_int(ext_t v, logic signed [17:0] lim);
		logic signed [17:0] u;
		u = $signed({3'h0, v.exp}) - `EXT_BIAS;
		if (v.exp == 15'h0 || u < 18'sh0) return 65'h0;
		if (u >= lim) return {1'b1, 64'h0};
		return {1'b0, v.sig >> (6'h3f - u[5:0])};
	endfunction

	// extended form to the destination image; filler and unused high bits zero
	function automatic res_t from_ext(fmt_t fmt, ext_t v);
		logic [64:0]        t;
		logic [63:0]        iv;
		logic signed [17:0] ne;
		logic [71:0]        bcd;
		res_t               r;
		r   = '0;
		iv  = 64'h0;
		bcd = 72'h0;
		ne  = $signed({3'h0, v.exp}) - `EXT_BIAS;
		case (fmt)
			FMT_INT16, FMT_INT32, FMT_INT64: begin
				t  = trunc_int(v, (fmt == FMT_INT16) ? 18'sh0000f : (fmt == FMT_INT32) ? 18'sh0001f : `INT_TOP);
				iv = v.sign ? 64'(-t[63:0]) : t[63:0];
				r.range_err = t[64];
				if (fmt == FMT_INT16) r.data = {64'h0, t[64] ? `INT16_INDEF : iv[15:0]};
				else if (fmt == FMT_INT32) r.data = {48'h0, t[64] ? `INT32_INDEF : iv[31:0]};
				else r.data = {16'h0, t[64] ? `INT64_INDEF : iv};
			end
			FMT_SGL: begin
				ne = ne + `SGL_BIAS;
				if (v.exp == `EXT_EXP_MAX) r.data = {48'h0, v.sign, 8'hff, v.sig[62:40]};
				else if (v.sig == 64'h0) r.data = {48'h0, v.sign, 31'h0};
				else if (ne >= `SGL_EMAX) begin
					r.data = {48'h0, v.sign, 8'hff, 23'h0};
					r.range_err = 1'b1;
				end else if (ne <= 18'sh0) begin
					r.data = {48'h0, v.sign, 31'h0};
					r.range_err = 1'b1;
				end else r.data = {48'h0, v.sign, ne[7:0], v.sig[62:40]};
			end
			FMT_DBL: begin
				ne = ne + `DBL_BIAS;
				if (v.exp == `EXT_EXP_MAX) r.data = {16'h0, v.sign, 11'h7ff, v.sig[62:11]};
				else if (v.sig == 64'h0) r.data = {16'h0, v.sign, 63'h0};
				else if (ne >= `DBL_EMAX) begin
					r.data = {16'h0, v.sign, 11'h7ff, 52'h0};
					r.range_err = 1'b1;
				end else if (ne <= 18'sh0) begin
					r.data = {16'h0, v.sign, 63'h0};
					r.range_err = 1'b1;
				end else r.data = {16'h0, v.sign, ne[10:0], v.sig[62:11]};
			end
			FMT_BCD: begin
				t = trunc_int(v, `INT_TOP);
				// shift-and-add-three, one source bit per pass
				for (int i = 63; i >= 0; i--) begin
					for (int d = 0; d < `BCD_DIGITS; d++) begin
						if (bcd[4*d +: 4] >= 4'h5) bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
					end
					bcd = {bcd[70:0], t[i]};
				end
				r.range_err = t[64] || (t[63:0] >= `BCD_LIMIT);
				r.data = r.range_err ? 80'h0 : {v.sign, 7'h0, bcd};
			end
			default: r.data = v;
		endcase
		return r;
	endfunction

	// ordered compare of two extended values; zeros of either sign are equal
	function automatic res_t compare(ext_t a, ext_t b);
		logic nan_a;
		logic nan_b;
		logic zero_ab;
		res_t r;
		r       = '0;
		nan_a   = (a.exp == `EXT_EXP_MAX) && (a.sig[62:0] != 63'h0);
		nan_b   = (b.exp == `EXT_EXP_MAX) && (b.sig[62:0] != 63'h0);
		zero_ab = (a.sig == 64'h0) && (b.sig == 64'h0);
		if (nan_a || nan_b) r.unordered = 1'b1;
		else if (zero_ab || a == b) r.equal = 1'b1;
		else if (a.sign != b.sign) r.less = a.sign;
		else r.less = a.sign ^ ({a.exp, a.sig} < {b.exp, b.sig});
		return r;
	endfunction

	// ------------------------------------------------------------
	// command slot
	// ------------------------------------------------------------
	logic   hold_v_ff;
	logic   nxt_hold_v;
	cmd_t   hold_ff;
	cmd_t   nxt_hold;
	logic   ready_ff;
	logic   nxt_ready;
	logic   take;

	// the slot refills while the datapath runs; the host waits only while the slot holds a command not yet taken
	always_comb begin
		nxt_hold_v = hold_v_ff;
		nxt_hold   = hold_ff;
		if (take) nxt_hold_v = 1'b0;
		if (CMD_VALID && ready_ff) begin
			nxt_hold   = CMD_IN;
			nxt_hold_v = 1'b1;
		end
		nxt_ready = ~nxt_hold_v;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			hold_v_ff <= 1'b0;
			hold_ff   <= '0;
			ready_ff  <= 1'b1;
		end else begin
			hold_v_ff <= nxt_hold_v;
			hold_ff   <= nxt_hold;
			ready_ff  <= nxt_ready;
		end
	end

	// ------------------------------------------------------------
	// execution unit
	// ------------------------------------------------------------
	state_t       state_ff, nxt_state;
	cmd_t         cur_ff, nxt_cur;
	logic [2:0]   top_ff, nxt_top;
	ext_t         a_ff, nxt_a;
	ext_t         b_ff, nxt_b;
	res_t         res_ff, nxt_res;
	logic         res_v_ff, nxt_res_v;
	logic         busy_ff, nxt_busy;
	logic [127:0] rad_ff, nxt_rad;
	logic [65:0]  rem_ff, nxt_rem;
	logic [63:0]  root_ff, nxt_root;
	logic [6:0]   cnt_ff, nxt_cnt;
	logic [14:0]  sq_exp_ff, nxt_sq_exp;
	logic         wr_en;
	logic [2:0]   wr_addr;
	ext_t         wr_data;
	logic [2:0]   rd_addr;
	ext_t         rd_data;
	logic [65:0]  rem_sh;
	logic [65:0]  trial;
	logic signed [17:0] sq_u;

	// one root bit per cycle; slower than a full array but small and easy to time
	always_comb begin
		nxt_state  = state_ff;
		nxt_cur    = cur_ff;
		nxt_top    = top_ff;
		nxt_a      = a_ff;
		nxt_b      = b_ff;
		nxt_res    = res_ff;
		nxt_res_v  = 1'b0;
		nxt_rad    = rad_ff;
		nxt_rem    = rem_ff;
		nxt_root   = root_ff;
		nxt_cnt    = cnt_ff;
		nxt_sq_exp = sq_exp_ff;
		take       = 1'b0;
		wr_en      = 1'b0;
		wr_addr    = top_ff;
		wr_data    = a_ff;
		rd_addr    = top_ff;
		rem_sh     = {rem_ff[63:0], rad_ff[127:126]};
		trial      = {root_ff, 2'b01};
		sq_u       = $signed({3'h0, a_ff.exp}) - `EXT_BIAS;
		case (state_ff)
			S_IDLE: begin
				if (hold_v_ff) begin
					take      = 1'b1;
					nxt_cur   = hold_ff;
					nxt_state = (hold_ff.op == OP_LOAD) ? S_EXEC : S_WAIT_A;
				end
			end
			S_WAIT_A: begin
				nxt_a   = rd_data;
				rd_addr = top_ff + cur_ff.idx;
				if (cur_ff.op == OP_COMPARE && cur_ff.use_reg) nxt_state = S_WAIT_B;
				else begin
					nxt_b     = to_ext(cur_ff.fmt, cur_ff.operand);
					nxt_state = S_EXEC;
				end
			end
			S_WAIT_B: begin
				nxt_b     = rd_data;
				nxt_state = S_EXEC;
			end
			S_EXEC: begin
				nxt_state = S_IDLE;
				case (cur_ff.op)
					OP_LOAD: begin
						wr_en   = 1'b1;
						wr_addr = top_ff - 3'h1;
						wr_data = to_ext(cur_ff.fmt, cur_ff.operand);
						nxt_top = top_ff - 3'h1;
					end
					OP_STORE, OP_STORE_POP: begin
						nxt_res   = from_ext(cur_ff.fmt, a_ff);
						nxt_res_v = 1'b1;
						if (cur_ff.op == OP_STORE_POP) nxt_top = top_ff + 3'h1;
					end
					OP_COMPARE: begin
						nxt_res   = compare(a_ff, b_ff);
						nxt_res_v = 1'b1;
					end
					default: begin
						// zero, denormal, negative and infinite operands skip the loop
						if (a_ff.exp == 15'h0 || a_ff.sig == 64'h0) begin
							wr_en   = 1'b1;
							wr_data = {a_ff.sign, 79'h0};
						end else if (a_ff.sign) begin
							wr_en   = 1'b1;
							wr_data = {1'b1, `EXT_EXP_MAX, `QNAN_SIG};
						end else if (a_ff.exp == `EXT_EXP_MAX) begin
							wr_en = 1'b1;
						end else begin
							nxt_rad    = sq_u[0] ? {a_ff.sig, 64'h0} : {1'b0, a_ff.sig, 63'h0};
							nxt_rem    = 66'h0;
							nxt_root   = 64'h0;
							nxt_cnt    = `SQRT_STEPS;
							nxt_sq_exp = 15'((sq_u >>> 1) + `EXT_BIAS);
							nxt_state  = S_SQRT;
						end
					end
				endcase
			end
			S_SQRT: begin
				nxt_rad  = {rad_ff[125:0], 2'b00};
				nxt_cnt  = cnt_ff - 7'h1;
				nxt_rem  = (rem_sh >= trial) ? 66'(rem_sh - trial) : rem_sh;
				nxt_root = {root_ff[62:0], (rem_sh >= trial)};
				if (cnt_ff == 7'h1) begin
					wr_en     = 1'b1;
					wr_data   = {1'b0, sq_exp_ff, nxt_root};
					nxt_state = S_IDLE;
				end
			end
			default: nxt_state = S_IDLE;
		endcase
		nxt_busy = (nxt_state != S_IDLE) || nxt_hold_v;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_ff  <= S_IDLE;
			cur_ff    <= '0;
			top_ff    <= `RESET_TOP;
			a_ff      <= '0;
			b_ff      <= '0;
			res_ff    <= '0;
			res_v_ff  <= 1'b0;
			busy_ff   <= 1'b0;
			rad_ff    <= 128'h0;
			rem_ff    <= 66'h0;
			root_ff   <= 64'h0;
			cnt_ff    <= 7'h0;
			sq_exp_ff <= 15'h0;
		end else begin
			state_ff  <= nxt_state;
			cur_ff    <= nxt_cur;
			top_ff    <= nxt_top;
			a_ff      <= nxt_a;
			b_ff      <= nxt_b;
			res_ff    <= nxt_res;
			res_v_ff  <= nxt_res_v;
			busy_ff   <= nxt_busy;
			rad_ff    <= nxt_rad;
			rem_ff    <= nxt_rem;
			root_ff   <= nxt_root;
			cnt_ff    <= nxt_cnt;
			sq_exp_ff <= nxt_sq_exp;
		end
	end

	// ------------------------------------------------------------
	// data registers and outputs
	// ------------------------------------------------------------
	stack_regfile #(
		.WIDTH (80),
		.DEPTH (NREGS),
		.AW    (3)
	) u_regs (
		.clk     (CORE_CLK),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	assign CMD_READY = ready_ff;
	assign RES_VALID = res_v_ff;
	assign RES_OUT   = res_ff;
	assign BUSY      = busy_ff;
	assign TOP_OUT   = top_ff;
endmodule

`default_nettype wire

// ===== tb/numeric_format_converter_sva.sv
// port assertions of the numeric format converter
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module numeric_format_converter_sva
	import fpfmt_pkg::*;
#(
	parameter int unsigned NREGS = 8
) (
	input wire logic       CORE_CLK,  // clock
	input wire logic       RST,       // reset
	input wire logic       CMD_VALID, // offer
	input wire logic       CMD_READY, // slot free
	input wire cmd_t       CMD_IN,    // command
	input wire logic       RES_VALID, // result strobe
	input wire res_t       RES_OUT,   // result
	input wire logic       BUSY,      // busy
	input wire logic [2:0] TOP_OUT    // stack top
);
	// ----------------
	// helpers
	// ----------------
	logic take;
	logic idle;
	// only a take into an idle datapath has a fixed timeline
	assign take = CMD_VALID && CMD_READY;
	assign idle = take && !BUSY;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// ----------------
	// assertions
	// ----------------
	a_reset_idle: assert property ($fell(RST) |-> CMD_READY && !RES_VALID && !BUSY && TOP_OUT == 3'h0)
		else $error("outputs not idle after reset");
	a_take_blocks: assert property (take |=> !CMD_READY && BUSY)
		else $error("slot still free after a take");
	a_idle_free: assert property (!BUSY |-> CMD_READY)
		else $error("slot full while idle");
	a_ready_back: assert property ($fell(CMD_READY) |-> ##[1:100] CMD_READY)
		else $error("slot never freed");
	a_load_push: assert property (idle && CMD_IN.op == OP_LOAD |-> ##3 TOP_OUT == $past(TOP_OUT, 3) - 3'h1)
		else $error("load did not push");
	a_store_time: assert property (idle && CMD_IN.op inside {OP_STORE, OP_STORE_POP} |=> !RES_VALID [*3] ##1 RES_VALID)
		else $error("store result late or early");
	a_pop_top: assert property (idle && CMD_IN.op == OP_STORE_POP |-> ##4 TOP_OUT == $past(TOP_OUT, 4) + 3'h1)
		else $error("store and pop did not pop");
	a_result_hold: assert property (!RES_VALID && !$past(RST) |-> $stable(RES_OUT))
		else $error("result changed without strobe");
	a_result_cause: assert property (RES_VALID |-> $past(BUSY))
		else $error("result without a command");
	a_flags_one: assert property (RES_VALID |-> $onehot0({RES_OUT.less, RES_OUT.equal, RES_OUT.unordered}))
		else $error("compare flags conflict");
	a_root_quiet: assert property (idle && CMD_IN.op == OP_SQRT |=> (BUSY && !RES_VALID && $stable(TOP_OUT)) [*8])
		else $error("root ended early or moved top");
endmodule
bind numeric_format_converter numeric_format_converter_sva #(.NREGS(NREGS)) i_sva (.CORE_CLK(CORE_CLK), .RST(RST),
	.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_IN(CMD_IN), .RES_VALID(RES_VALID), .RES_OUT(RES_OUT),
	.BUSY(BUSY), .TOP_OUT(TOP_OUT));
`default_nettype wire

// ===== tb/host_model.sv
// host side: queues whole commands and offers them on the command port
// assumes the bench pushes commands and drives hold_off
`timescale 1ns/100ps
`default_nettype none
module host_model
	import fpfmt_pkg::*;
(
	input  wire logic clk,       // clock
	input  wire logic rst,       // reset
	input  wire logic cmd_ready, // slot free
	input  wire logic hold_off,  // stall new offers
	output logic      cmd_valid, // offer
	output cmd_t      cmd_in     // command
);
	cmd_t pend[$];
	// the host did the memory reads, aligned or not; operands come whole
	function automatic void push(cmd_t c);
		pend.push_back(c);
	endfunction
	initial begin
		cmd_valid = 1'b0;
		cmd_in = '0;
	end
	// an offer stands until taken; an idle bus shows a changing pattern
	always @(posedge clk) begin
		if (!rst && cmd_valid && cmd_ready)
			void'(pend.pop_front());
		if (rst || !cmd_valid || cmd_ready) begin
			if (!rst && !hold_off && pend.size() != 0) begin
				cmd_valid <= 1'b1;
				cmd_in <= pend[0];
			end else begin
				cmd_valid <= 1'b0;
				cmd_in <= cmd_t'(~cmd_in);
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/test_numeric_format_converter.sv
// self-checking bench of the numeric format converter
// assumes the host model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module test_numeric_format_converter;
	import fpfmt_pkg::*;
	typedef struct packed {
		logic [79:0] data;
		logic [79:0] mask;
		logic [3:0]  flags;
	} exp_t;
	logic        core_clk;
	logic        rst;
	logic        cmd_valid;
	logic        cmd_ready;
	cmd_t        cmd_in;
	logic        res_valid;
	res_t        res_out;
	logic        busy;
	logic [2:0]  top_out;
	logic        hold_off;
	logic        slow;
	logic [63:0] r;
	logic [71:0] dg;
	integer      seed = 32'h6150;
	int          n_fail = 0;
	int          n_checks = 0;
	int          n_overlap = 0;
	int          e;
	int          w;
	longint      v;
	longint      a;
	longint      b;
	exp_t        exp_q[$];
	fmt_t        ifmt[3] = '{FMT_INT16, FMT_INT32, FMT_INT64};

	numeric_format_converter #(.NREGS(8)) i_dut (.CORE_CLK(core_clk), .RST(rst), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_IN(cmd_in), .RES_VALID(res_valid), .RES_OUT(res_out), .BUSY(busy),
		.TOP_OUT(top_out));
	host_model i_host (.clk(core_clk), .rst(rst), .cmd_ready(cmd_ready), .hold_off(hold_off),
		.cmd_valid(cmd_valid), .cmd_in(cmd_in));

	// ----------------
	// helpers
	// ----------------
	function automatic logic [63:0] rnd64();
		return {$random(seed), $random(seed)};
	endfunction
	function automatic logic [79:0] fmask(fmt_t f);
		case (f)
			FMT_INT16: return 80'hffff;
			FMT_INT32, FMT_SGL: return 80'hffff_ffff;
			FMT_INT64, FMT_DBL: return {16'h0, {64{1'b1}}};
			default: return {80{1'b1}};
		endcase
	endfunction
	// integer to real image, significand truncated
	function automatic logic [79:0] int_img(longint x, fmt_t f);
		logic [63:0] m;
		int ex;
		m = x < 0 ? -x : x;
		ex = 63;
		while (!m[63]) begin
			m = m << 1;
			ex--;
		end
		case (f)
			FMT_SGL: return {48'h0, x < 0, 8'(ex + 127), m[62:40]};
			FMT_DBL: return {16'h0, x < 0, 11'(ex + 1023), m[62:11]};
			default: return {x < 0, 15'(ex + 16383), m};
		endcase
	endfunction
	function automatic longint bcd_val(logic [71:0] d);
		longint s;
		s = 0;
		for (int i = 17; i >= 0; i--)
			s = s * 10 + d[i*4 +: 4];
		return s;
	endfunction
	task automatic issue(op_t op, fmt_t f, logic [79:0] d, logic ur = 1'b0, logic [2:0] ix = 3'h0);
		i_host.push('{op: op, fmt: f, use_reg: ur, idx: ix, operand: d});
	endtask
	task automatic st(op_t op, fmt_t f, logic [79:0] d, logic err);
		issue(op, f, 80'h0);
		exp_q.push_back('{d, fmask(f), {err, 3'h0}});
	endtask
	task automatic cmp(logic ur, logic [79:0] d, logic [3:0] fl);
		issue(OP_COMPARE, FMT_INT16, d, ur, 3'h1);
		exp_q.push_back('{80'h0, 80'h0, fl});
	endtask
	task automatic check_val(string name, logic [79:0] x, logic [79:0] y);
		n_checks++;
		if (y !== x) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, x, y);
		end
	endtask
	task automatic check_res(exp_t x);
		check_val("result data", x.data & x.mask, res_out.data & x.mask);
		check_val("result flags", 80'(x.flags), 80'({res_out.range_err, res_out.less, res_out.equal, res_out.unordered}));
	endtask
	// waits off the edge so that no update of the edge is half seen
	task automatic wait_idle(string name);
		int n;
		n = 0;
		while ((i_host.pend.size() != 0 || exp_q.size() != 0 || busy !== 1'b0 || cmd_valid) && n < 2000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 2000)
			check_val("idle", 80'h0, 80'h1);
		$display("test %s ended: %0d checks %0d fails", name, n_checks, n_fail);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------
	// processes
	// ----------------
	always #2 core_clk = ~core_clk;
	// random host stalls while slow is set
	always @(posedge core_clk) begin
		hold_off <= slow && $random(seed) % 2 != 0;
	end
	// results come in command order, so the oldest note matches
	always @(posedge core_clk) begin
		if (!rst && res_valid !== 1'b0) begin
			if (exp_q.size() == 0)
				check_val("spare result", 80'h0, res_out.data);
			else
				check_res(exp_q.pop_front());
		end
		if (!rst && cmd_valid && cmd_ready === 1'b1 && busy === 1'b1)
			n_overlap++;
	end
	// watchdog, well past the expected run length
	initial begin
		#200000;
		n_fail++;
		$display("BAD watchdog expected end seen hang");
		final_report();
	end
	// main sequence
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		slow = 1'b0;
		hold_off = 1'b0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		check_val("ready after reset", 80'h1, 80'(cmd_ready));
		check_val("top after reset", 80'h0, 80'(top_out));
		slow = 1'b1;
		// integers, the first of each width the negative limit
		foreach (ifmt[j]) begin
			for (int i = 0; i < 5; i++) begin
				w = ifmt[j] == FMT_INT16 ? 16 : ifmt[j] == FMT_INT32 ? 32 : 64;
				v = (i == 0) ? -(longint'(1) <<< (w - 1)) : $signed(rnd64()) >>> (66 - w);
				if (v == 0)
					v = 1;
				wait_idle("int step");
				issue(OP_LOAD, ifmt[j], {rnd64(), 16'h0} & ~fmask(ifmt[j]) | 80'(v) & fmask(ifmt[j]));
				st(OP_STORE, FMT_SGL, int_img(v, FMT_SGL), 1'b0);
				st(OP_STORE, FMT_DBL, int_img(v, FMT_DBL), 1'b0);
				st(OP_STORE, FMT_EXT, int_img(v, FMT_EXT), 1'b0);
				st(OP_STORE_POP, ifmt[j], 80'(v), i == 0);
			end
		end
		// reals rebiased both ways
		for (int i = 0; i < 5; i++) begin
			r = rnd64();
			e = 1 + r[39:32] % 254;
			issue(OP_LOAD, FMT_SGL, {48'h0, r[63], 8'(e), r[22:0]});
			st(OP_STORE, FMT_DBL, {16'h0, r[63], 11'(e + 896), r[22:0], 29'h0}, 1'b0);
			st(OP_STORE, FMT_EXT, {r[63], 15'(e + 16256), 1'b1, r[22:0], 40'h0}, 1'b0);
			st(OP_STORE_POP, FMT_SGL, {48'h0, r[63], 8'(e), r[22:0]}, 1'b0);
			e = 1 + r[50:40] % 2046;
			issue(OP_LOAD, FMT_DBL, {16'h0, r[63], 11'(e), r[51:0]});
			st(OP_STORE, FMT_EXT, {r[63], 15'(e + 15360), 1'b1, r[51:0], 11'h0}, 1'b0);
			st(OP_STORE_POP, FMT_DBL, {16'h0, r[63], 11'(e), r[51:0]}, 1'b0);
		end
		wait_idle("reals");
		// decimal with filler set on load
		for (int i = 0; i < 4; i++) begin
			r = rnd64();
			for (int k = 0; k < 18; k++)
				dg[k*4 +: 4] = 4'(($random(seed) & 32'h7fff_ffff) % 10);
			dg[3:0] = 4'h7;
			v = bcd_val(dg);
			issue(OP_LOAD, FMT_BCD, {r[0], r[7:1] | 7'h40, dg});
			st(OP_STORE, FMT_INT64, 80'(r[0] ? -v : v), 1'b0);
			st(OP_STORE_POP, FMT_BCD, {r[0], 7'h0, dg}, 1'b0);
		end
		wait_idle("decimal");
		// compare against a register and against memory
		for (int i = 0; i < 4; i++) begin
			a = $signed(rnd64()) >>> 50;
			b = i == 0 ? a : $signed(rnd64()) >>> 50;
			issue(OP_LOAD, FMT_INT16, 80'(a));
			issue(OP_LOAD, FMT_INT16, 80'(b));
			cmp(1'b1, 80'h0, {1'b0, b < a, b == a, 1'b0});
			cmp(1'b0, 80'(b), 4'h2);
			wait_idle("compare step");
			st(OP_STORE_POP, FMT_INT16, 80'(b), 1'b0);
			wait_idle("compare pop");
			st(OP_STORE_POP, FMT_INT16, 80'(a), 1'b0);
		end
		// root of the top only, next command queued while it runs
		for (int i = 0; i < 3; i++) begin
			v = 1 + ($random(seed) & 32'h7fff);
			issue(OP_LOAD, FMT_INT16, 80'h7);
			issue(OP_LOAD, FMT_INT32, 80'(v * v));
			wait_idle("root setup");
			issue(OP_SQRT, FMT_EXT, 80'h0);
			st(OP_STORE_POP, FMT_INT32, 80'(v), 1'b0);
			st(OP_STORE_POP, FMT_INT16, 80'h7, 1'b0);
		end
		// extended image in, single overflows to infinity, double keeps it
		r = rnd64();
		issue(OP_LOAD, FMT_EXT, {r[63], 15'h40c7, 1'b1, r[62:0]});
		st(OP_STORE, FMT_SGL, {48'h0, r[63], 8'hff, 23'h0}, 1'b1);
		st(OP_STORE_POP, FMT_DBL, {16'h0, r[63], 11'h4c7, r[62:11]}, 1'b0);
		// no stalls: the short negative root must never find an idle datapath
		slow = 1'b0;
		issue(OP_LOAD, FMT_INT16, 80'hfffc);
		issue(OP_SQRT, FMT_EXT, 80'h0);
		st(OP_STORE_POP, FMT_EXT, {1'b1, 15'h7fff, 64'hc000_0000_0000_0000}, 1'b0);
		wait_idle("root");
		check_val("takes while busy", 80'h1, 80'(n_overlap != 0));
		final_report();
	end
endmodule
`default_nettype wire
